// >>> dmrs_assertions.sv
// Purpose: port checks for the first loop mode select
// Assumes: no priority of 7, reads held at 0x33
// Notes: loop outputs lag their causes by a few edges
`timescale 1ns/1ns
module dmrs_chk
   import dmrs_pkg::*;
(
   // clock and reset
   input wire logic SYS_CLK_IN,
   input wire logic RESET_IN,
   // register port
   input wire logic [7:0] REG_ADDR_IN,
   input wire logic [7:0] REG_WDATA_IN,
   input wire logic REG_WR_IN,
   input wire logic [7:0] REG_RDATA_OUT,
   // references and feedback
   input wire logic [3:0] REF_AVAIL_IN,
   input wire logic [11:0] REF_PRIO_IN,
   input wire logic [15:0] EXT_FB_PHASE_IN,
   // loop steering
   input wire logic [1:0] LOOP_STATE_OUT,
   input wire logic [1:0] LOOP_REF_OUT,
   input wire logic LOOP_USE_OSC_OUT,
   input wire logic [15:0] LOOP_FB_PHASE_OUT
);
   // ==========
   // readback view, valid only while the register is addressed
   wire a = REG_ADDR_IN == 8'h33;
   wire [1:0] m = REG_RDATA_OUT[1:0];
   wire [1:0] s = REG_RDATA_OUT[7:6];
   default clocking @(posedge SYS_CLK_IN); endclocking
   default disable iff (RESET_IN);
   // settled inputs, long enough to cover sync and chooser lag
   sequence s_calm(logic [1:0] md);
      a && m == md && $stable(REF_AVAIL_IN) && $stable(REF_PRIO_IN) && $stable(REG_RDATA_OUT);
   endsequence
   // ==========
   // mode checks
   property p_free;
      (a && m == 2'h0)[*2] |-> LOOP_STATE_OUT == 2'h0 && LOOP_USE_OSC_OUT;
   endproperty
   a_free: assert property (p_free) else $error("freerun not on oscillator");
   property p_hold;
      (a && m == 2'h1)[*2] |-> LOOP_STATE_OUT == 2'h1 && !LOOP_USE_OSC_OUT;
   endproperty
   a_hold: assert property (p_hold) else $error("holdover not entered");
   property p_forced;
      s_calm(2'h2)[*5] |-> LOOP_STATE_OUT == (REF_AVAIL_IN[s] ? 2'h2 : 2'h1)
         && (!REF_AVAIL_IN[s] || LOOP_REF_OUT == s);
   endproperty
   a_forced: assert property (p_forced) else $error("forced lock wrong");
   property p_auto_state;
      s_calm(2'h3)[*6] |-> LOOP_STATE_OUT == (|REF_AVAIL_IN ? 2'h2 : 2'h1);
   endproperty
   a_auto_state: assert property (p_auto_state) else $error("auto state wrong");
   property p_auto_ref;
      (s_calm(2'h3) && |REF_AVAIL_IN)[*6] |-> LOOP_REF_OUT == s && REF_AVAIL_IN[s];
   endproperty
   a_auto_ref: assert property (p_auto_ref) else $error("auto status mismatch");
   property p_fb_on;
      a && REG_RDATA_OUT[5] |=> LOOP_FB_PHASE_OUT == $past(EXT_FB_PHASE_IN);
   endproperty
   a_fb_on: assert property (p_fb_on) else $error("feedback phase not used");
   property p_fb_off;
      (a && !REG_RDATA_OUT[5])[*2] |-> LOOP_FB_PHASE_OUT == 16'h0000;
   endproperty
   a_fb_off: assert property (p_fb_off) else $error("feedback not ignored");
   // auto-mode writes drop the choice bits, so only non-auto writes echo whole
   property p_write;
      REG_WR_IN && a && m != 2'h3 && REG_WDATA_IN[1:0] != 2'h3
         |=> !a || REG_RDATA_OUT == $past(REG_WDATA_IN);
   endproperty
   a_write: assert property (p_write) else $error("register write lost");
   c_lock: cover property (a && m == 2'h2 && LOOP_STATE_OUT == 2'h2);
   c_auto_hold: cover property (a && m == 2'h3 && LOOP_STATE_OUT == 2'h1);
   c_fb: cover property (LOOP_FB_PHASE_OUT != 16'h0000);
endmodule : dmrs_chk

bind dmrs_mode_refsel dmrs_chk u_chk (.SYS_CLK_IN, .RESET_IN, .REG_ADDR_IN, .REG_WDATA_IN,
   .REG_WR_IN, .REG_RDATA_OUT, .REF_AVAIL_IN, .REF_PRIO_IN, .EXT_FB_PHASE_IN,
   .LOOP_STATE_OUT, .LOOP_REF_OUT, .LOOP_USE_OSC_OUT, .LOOP_FB_PHASE_OUT);

// >>> dmrs_auto_select.sv
// Purpose: automatic reference chooser
// Assumes: availability and priorities on the same clock
// Notes: revertive across priorities, non-revertive within one
`timescale 1ns/1ns
module dmrs_auto_select
   import dmrs_pkg::*;
(
   // clock and reset
   input wire logic clk_in,
   input wire logic rst_in,
   // control
   input wire logic enable_in,
   input wire logic [3:0] avail_in,
   input wire logic [11:0] prio_in,
   // result
   output logic [1:0] sel_out,
   output logic any_out
);
   // ==========================================
   // best candidate search
   logic [1:0] sel_r;
   logic [1:0] best;
   logic [2:0] best_p;
   logic found;
   logic [2:0] cur_p;
   logic cur_ok;
   logic [3:0] usable;

   genvar g;
   generate
      for (g = 0; g < DMRS_NUM_REFS; g++) begin : g_use
         assign usable[g] = avail_in[g] && (prio_in[3*g +: 3] != DMRS_PRIO_DISABLED);
      end
   endgenerate

   // lowest number wins, first index on ties
   always_comb begin
      best = 2'h0;
      best_p = DMRS_PRIO_DISABLED;
      found = 1'b0;
      for (int i = 0; i < DMRS_NUM_REFS; i++) begin
         if (usable[i] && (!found || prio_in[3*i +: 3] < best_p)) begin
            best = i[1:0];
            best_p = prio_in[3*i +: 3];
            found = 1'b1;
         end
      end
   end

   assign cur_p = prio_in[3*sel_r +: 3];
   assign cur_ok = usable[sel_r];
   assign any_out = found;
   assign sel_out = sel_r;

   // keep current on equal priority; move to strictly better or when current fails
   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         sel_r <= 2'h0;
      end else if (enable_in && found && (!cur_ok || best_p < cur_p)) begin
         sel_r <= best;
      end
   end
endmodule : dmrs_auto_select

// >>> dmrs_mode_refsel.sv
// Purpose: mode and reference selection register for the first loop
// Assumes: byte register port from the serial interface, same clock
// Notes: availability inputs are synchronised here
// ==========================================
// timing summary
// a register write takes effect at the edge that sees the strobe
// readback is combinational, so a read sees the new byte right away
// reference availability pins cross two flops before any decision
// the automatic choice adds one edge, loop steering one more
// priorities come on this clock, so a priority change acts at once
// feedback phase is registered once, one edge behind its input
//
// hazards and limitations
// a write in automatic mode drops the choice bits; they are status there
// leaving automatic mode keeps the last forced choice, not the auto pick
// reserved bits are stored and read back so software can restore them
// holdover reports the last locked reference as its frequency source
// the feedback phase is zeroed when unused, so the loop needs no mux
// a reference with priority seven never counts as available in auto
// the chooser keeps its pick while out of auto, so re-entry is hitless
`timescale 1ns/1ns
module dmrs_mode_refsel
   import dmrs_pkg::*;
(
   // clock and reset
   input wire logic SYS_CLK_IN,
   input wire logic RESET_IN,
   // register port
   input wire logic [7:0] REG_ADDR_IN,
   input wire logic [7:0] REG_WDATA_IN,
   input wire logic REG_WR_IN,
   output logic [7:0] REG_RDATA_OUT,
   // reference status and priorities
   input wire logic [3:0] REF_AVAIL_IN,
   input wire logic [11:0] REF_PRIO_IN,
   // feedback phase
   input wire logic [15:0] EXT_FB_PHASE_IN,
   // loop steering
   output logic [1:0] LOOP_STATE_OUT,
   output logic [1:0] LOOP_REF_OUT,
   output logic LOOP_USE_OSC_OUT,
   output logic [15:0] LOOP_FB_PHASE_OUT
);
   // ==========================================
   // register fields, split out of the stored byte
   logic [1:0] mode_r;
   logic fb_en_r;
   logic [1:0] choice_r;
   logic [2:0] rsvd_r;
   // synchronised reference availability
   logic [3:0] avail_s1_r;
   logic [3:0] avail_r;
   // loop steering state; holdover needs the last locked index
   logic [1:0] last_ref_r;
   logic [1:0] last_ref_nxt;
   dmrs_ctrl_s ctrl_r;
   dmrs_ctrl_s ctrl_nxt;
   logic [15:0] fb_phase_r;
   logic [15:0] fb_phase_nxt;
   // automatic chooser results
   logic [1:0] auto_sel;
   logic auto_any;
   // decode and selection wires
   logic addr_hit;
   logic wr_hit;
   logic is_auto;
   logic forced_ok;
   logic [1:0] shown_sel;
   logic [7:0] rd_word;

   // ==========================================
   // address decode, shared by the write path and the readback mux
   function automatic logic mode_reg_hit(input logic [7:0] addr);
      return addr == DMRS_MODE_REFSEL_ADDR;
   endfunction : mode_reg_hit

   // write strobe and mode decode
   assign addr_hit = mode_reg_hit(REG_ADDR_IN);
   assign wr_hit = REG_WR_IN && addr_hit;
   assign is_auto = (mode_r == DMRS_MODE_AUTO);
   // forced lock only holds while the chosen pin is seen available
   assign forced_ok = avail_r[choice_r];

   // register write; selection bits are status in auto, so writes there are dropped
   always_ff @(posedge SYS_CLK_IN or posedge RESET_IN) begin
      if (RESET_IN) begin
         mode_r <= DMRS_MODE_REFSEL_RESET[DMRS_MODE_LSB +: 2];
         fb_en_r <= DMRS_MODE_REFSEL_RESET[DMRS_FB_BIT];
         choice_r <= DMRS_MODE_REFSEL_RESET[DMRS_SEL_LSB +: 2];
         rsvd_r <= DMRS_RSVD_RESET;
      end else if (wr_hit) begin
         mode_r <= REG_WDATA_IN[DMRS_MODE_LSB +: 2];
         fb_en_r <= REG_WDATA_IN[DMRS_FB_BIT];
         rsvd_r <= REG_WDATA_IN[4:2];
         if (!is_auto) begin
            choice_r <= REG_WDATA_IN[DMRS_SEL_LSB +: 2];
         end
      end
   end

   // ==========================================
   // availability synchroniser, pins are asynchronous
   always_ff @(posedge SYS_CLK_IN or posedge RESET_IN) begin
      if (RESET_IN) begin
         avail_s1_r <= 4'h0;
         avail_r <= 4'h0;
      end else begin
         avail_s1_r <= REF_AVAIL_IN;
         avail_r <= avail_s1_r;
      end
   end

   // ==========================================
   // automatic chooser
   dmrs_auto_select u_auto (
      .clk_in(SYS_CLK_IN),
      .rst_in(RESET_IN),
      .enable_in(is_auto),
      .avail_in(avail_r),
      .prio_in(REF_PRIO_IN),
      .sel_out(auto_sel),
      .any_out(auto_any)
   );

   // readback: status in auto, control value otherwise
   // the auto view is the chooser's register, so it moves with the commit
   assign shown_sel = is_auto ? auto_sel : choice_r;
   assign rd_word = {shown_sel, fb_en_r, rsvd_r, mode_r};
   // other addresses read zero; this block owns one byte only
   assign REG_RDATA_OUT = addr_hit ? rd_word : 8'h00;

   // ==========================================
   // loop state decision
   always_comb begin
      ctrl_nxt.ref_index = last_ref_r;
      ctrl_nxt.use_feedback = fb_en_r;
      ctrl_nxt.state = DMRS_LOOP_FREERUN;
      last_ref_nxt = last_ref_r;
      // all four codes are legal, so no default branch
      unique case (dmrs_mode_e'(mode_r))
         // oscillator only; choice field and references ignored
         DMRS_MODE_FREERUN: begin
            ctrl_nxt.state = DMRS_LOOP_FREERUN;
         end
         // hold the last locked reference frequency, ignore the rest
         DMRS_MODE_HOLDOVER: begin
            ctrl_nxt.state = DMRS_LOOP_HOLDOVER;
         end
         // never move to another reference, even if one is up
         DMRS_MODE_FORCED: begin
            if (forced_ok) begin
               ctrl_nxt.state = DMRS_LOOP_LOCKED;
               ctrl_nxt.ref_index = choice_r;
               last_ref_nxt = choice_r;
            end else begin
               ctrl_nxt.state = DMRS_LOOP_HOLDOVER;
            end
         end
         // chooser pick while any reference is usable, holdover otherwise
         DMRS_MODE_AUTO: begin
            if (auto_any) begin
               ctrl_nxt.state = DMRS_LOOP_LOCKED;
               ctrl_nxt.ref_index = auto_sel;
               last_ref_nxt = auto_sel;
            end else begin
               ctrl_nxt.state = DMRS_LOOP_HOLDOVER;
            end
         end
      endcase
   end

   // feedback phase is forced to zero when compensation is off
   assign fb_phase_nxt = fb_en_r ? EXT_FB_PHASE_IN : 16'h0000;

   // ==========================================
   // loop steering registers
   // holdover keeps the last locked reference index as its frequency source
   always_ff @(posedge SYS_CLK_IN or posedge RESET_IN) begin
      if (RESET_IN) begin
         ctrl_r <= '{state: DMRS_LOOP_FREERUN, ref_index: 2'h0, use_feedback: 1'b0};
         last_ref_r <= 2'h0;
         fb_phase_r <= 16'h0000;
      end else begin
         ctrl_r <= ctrl_nxt;
         last_ref_r <= last_ref_nxt;
         fb_phase_r <= fb_phase_nxt;
      end
   end

   // ==========================================
   // outputs straight from the steering flops; only the oscillator flag is decoded from the state
   assign LOOP_STATE_OUT = ctrl_r.state;
   assign LOOP_REF_OUT = ctrl_r.ref_index;
   assign LOOP_USE_OSC_OUT = (ctrl_r.state == DMRS_LOOP_FREERUN);
   assign LOOP_FB_PHASE_OUT = fb_phase_r;
endmodule : dmrs_mode_refsel

// >>> dmrs_pkg.sv
// Purpose: constants and types for the first loop mode and reference select block
// Assumes: one 8-bit register at index 0x33, reset 0x03
// Notes: priorities 0..6 valid, 7 disables a reference for automatic selection only
package dmrs_pkg;
   // ==========================================
   // register map
   localparam logic [7:0] DMRS_MODE_REFSEL_ADDR = 8'h33;
   localparam logic [7:0] DMRS_MODE_REFSEL_RESET = 8'h03;
   localparam int DMRS_MODE_LSB = 0;
   localparam int DMRS_FB_BIT = 5;
   localparam int DMRS_SEL_LSB = 6;
   localparam logic [2:0] DMRS_RSVD_RESET = 3'h0;
   localparam logic [2:0] DMRS_PRIO_DISABLED = 3'h7;
   localparam int DMRS_NUM_REFS = 4;

   // ==========================================
   // mode codes and loop states
   typedef enum logic [1:0] {
      DMRS_MODE_FREERUN = 2'h0,
      DMRS_MODE_HOLDOVER = 2'h1,
      DMRS_MODE_FORCED = 2'h2,
      DMRS_MODE_AUTO = 2'h3
   } dmrs_mode_e;

   typedef enum logic [1:0] {
      DMRS_LOOP_FREERUN,
      DMRS_LOOP_HOLDOVER,
      DMRS_LOOP_LOCKED
   } dmrs_loop_e;

   // loop steering bundle
   typedef struct packed {
      dmrs_loop_e state;
      logic [1:0] ref_index;
      logic use_feedback;
   } dmrs_ctrl_s;
endpackage : dmrs_pkg

// >>> tb_dmrs_mode_refsel.sv
// Purpose: self-checking bench for the mode select block
// Assumes: latencies settle within six cycles
// Notes: expectations are masked views of all outputs
`timescale 1ns/1ns
module tb_dmrs_mode_refsel
   import dmrs_pkg::*;
;
   logic SYS_CLK_IN = 0, RESET_IN = 1, REG_WR_IN = 0, obs = 0;
   logic [7:0] REG_ADDR_IN = 8'h33, REG_WDATA_IN = 8'h00, REG_RDATA_OUT;
   logic [3:0] REF_AVAIL_IN = 4'h0;
   logic [11:0] REF_PRIO_IN = 12'h000;
   logic [15:0] EXT_FB_PHASE_IN = 16'h0000, LOOP_FB_PHASE_OUT;
   logic [1:0] LOOP_STATE_OUT, LOOP_REF_OUT;
   logic LOOP_USE_OSC_OUT;
   int failures = 0, total_checks = 0;
   logic [57:0] q[$];
   logic [3:0] avs [3] = '{4'h2, 4'h3, 4'h7};
   logic [1:0] sls [3] = '{2'h1, 2'h1, 2'h2};
   wire [28:0] seen = {REG_RDATA_OUT, LOOP_STATE_OUT, LOOP_REF_OUT, LOOP_USE_OSC_OUT,
      LOOP_FB_PHASE_OUT};
   dmrs_mode_refsel DUT (.SYS_CLK_IN, .RESET_IN, .REG_ADDR_IN, .REG_WDATA_IN, .REG_WR_IN,
      .REG_RDATA_OUT, .REF_AVAIL_IN, .REF_PRIO_IN, .EXT_FB_PHASE_IN, .LOOP_STATE_OUT,
      .LOOP_REF_OUT, .LOOP_USE_OSC_OUT, .LOOP_FB_PHASE_OUT);
   // ==========
   // helpers
   task automatic check(input logic [28:0] v, e, k);
      total_checks++;
      if ((v & k) !== (e & k)) begin
         failures++;
         $display("[FAIL] outputs exp %h seen %h", e & k, v & k);
      end
   endtask : check
   task automatic note(input logic [28:0] k, e);
      q.push_back({k, e});
      obs = 1;
      @(negedge SYS_CLK_IN) obs = 0;
   endtask : note
   // settle wait covers sync, chooser and loop register lag
   task automatic wr(input logic [7:0] ad, d);
      @(negedge SYS_CLK_IN);
      REG_ADDR_IN = ad;
      REG_WDATA_IN = d;
      REG_WR_IN = 1;
      @(negedge SYS_CLK_IN) REG_WR_IN = 0;
      REG_ADDR_IN = 8'h33;
      repeat (6) @(negedge SYS_CLK_IN);
   endtask : wr
   task automatic print_verdict;
      if (failures == 0 && total_checks > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask : print_verdict
   // ==========
   // clock, watcher and watchdog
   initial forever #5 SYS_CLK_IN = ~SYS_CLK_IN;
   always @(posedge SYS_CLK_IN) begin
      if (obs && q.size() > 0) begin
         check(seen, q[0][28:0], q[0][57:29]);
         void'(q.pop_front());
      end
   end
   initial begin
      #20000;
      failures++;
      print_verdict();
   end
   // ==========
   // scenarios
   initial begin
      void'($urandom(32'he595ca13));
      repeat (12) @(negedge SYS_CLK_IN);
      RESET_IN = 0;
      note(29'h1FE00000, {8'h03, 21'h0});
      wr(8'h40, 8'h5A);
      for (int k = 0; k < 2; k++) begin
         wr(8'h33, {2'($urandom), 6'(k)});
         note(29'h190000, {8'h00, k[0] ? 2'h1 : 2'h0, 2'h0, ~k[0], 16'h0});
      end
      // odd passes lock, even ones lose only the chosen reference
      for (int i = 0; i < 4; i++) begin
         REF_AVAIL_IN = i[0] ? 4'($urandom) | (4'h1 << i) : ~(4'h1 << i);
         wr(8'h33, {i[1:0], 6'h02});
         note({8'hFF, 2'h3, i[0] ? 2'h3 : 2'h0, 1'b1, 16'h0},
            {i[1:0], 6'h02, i[0] ? 2'h2 : 2'h1, i[1:0], 1'b0, 16'h0});
      end
      EXT_FB_PHASE_IN = 16'($urandom);
      wr(8'h33, 8'h22);
      note(29'hFFFF, {13'h0, EXT_FB_PHASE_IN});
      wr(8'h33, 8'h02);
      note(29'hFFFF, 29'h0);
      REF_PRIO_IN = 12'h409;
      REF_AVAIL_IN = 4'h0;
      wr(8'h33, 8'h03);
      note(29'h180000, {8'h00, 2'h1, 19'h0});
      for (int j = 0; j < 3; j++) begin
         REF_AVAIL_IN = avs[j];
         repeat (6) @(negedge SYS_CLK_IN);
         note(29'h1FFF0000, {sls[j], 6'h03, 2'h2, sls[j], 1'b0, 16'h0});
      end
      wr(8'h33, 8'hC3);
      note(29'h1FE00000, {8'h83, 21'h0});
      print_verdict();
   end
endmodule : tb_dmrs_mode_refsel
